// >>> src/dtf_pkg.sv
package dtf_pkg;

  // Widths and channel layout
  localparam int unsigned TEMP_W = 11;
  localparam int unsigned CH_W = 3;
  localparam int unsigned NUM_REM = 4;
  localparam int unsigned NUM_CH = 5;
  localparam int unsigned NUM_FILT = 2;
  localparam int unsigned HIST_DEPTH = 8;
  localparam int unsigned PTR_W = 3;
  localparam logic [CH_W-1:0] CH_LAST = 3'h4;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_FILT = 8'h00;
  localparam logic [7:0] OFS_BCTL = 8'h04;
  localparam logic [7:0] OFS_BETA0 = 8'h08;
  localparam logic [7:0] OFS_IDEAL0 = 8'h18;
  localparam logic [7:0] OFS_TEMP0 = 8'h28;
  localparam logic [7:0] OFS_LAST = 8'h38;

  // Field positions inside the beta control word
  localparam int unsigned BCTL_AUTO_LSB = 0;
  localparam int unsigned BCTL_APD_LSB = 4;

  // Reset values, ideality limits and compensation masks
  localparam logic [1:0] FILT_RST = 2'h0;
  localparam logic [3:0] AUTO_RST = 4'hF;
  localparam logic [3:0] APD_RST = 4'h0;
  localparam logic [3:0] BETA_DIODE = 4'hF;
  localparam logic [5:0] IDEAL_RST = 6'h12;
  localparam logic [5:0] IDEAL_MIN = 6'h08;
  localparam logic [5:0] IDEAL_MAX = 6'h37;
  localparam logic [3:0] COMP_ALL = 4'hF;
  localparam logic [3:0] COMP_LOW_PAIR = 4'h3;

  // Averaging shifts for the two levels
  localparam int unsigned AVG4_SHIFT = 2;
  localparam int unsigned AVG8_SHIFT = 3;

  typedef enum logic [1:0] {
    DTF_LVL_NONE = 2'b00,
    DTF_LVL_AVG4 = 2'b01,
    DTF_LVL_AVG8 = 2'b10
  } dtf_lvl_t;

  // Filter field to averaging level
  function automatic dtf_lvl_t dtf_decode_lvl(input logic [1:0] f);
    dtf_lvl_t l;
    l = DTF_LVL_NONE;
    unique case (f)
      2'b00: l = DTF_LVL_NONE;
      2'b01, 2'b10: l = DTF_LVL_AVG4;
      2'b11: l = DTF_LVL_AVG8;
    endcase
    return l;
  endfunction

endpackage

// >>> src/dtf_avg.sv
`timescale 1ns/1ps
// Running-average history for one remote channel
module dtf_avg
  import dtf_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [TEMP_W-1:0] data_i,
  output logic [TEMP_W-1:0] avg4_o,
  output logic [TEMP_W-1:0] avg8_o
);

  logic [TEMP_W-1:0] hist_r [HIST_DEPTH];
  logic [PTR_W-1:0] ptr_r;
  logic primed_r;
  logic [TEMP_W+1:0] sum4_r;
  logic [TEMP_W+2:0] sum8_r;
  logic [TEMP_W-1:0] old8_w;
  logic [TEMP_W-1:0] old4_w;

  // Slot under the pointer is the oldest; four ahead drops out of four
  assign old8_w = hist_r[ptr_r];
  assign old4_w = hist_r[PTR_W'(ptr_r + 3'h4)];

  // History ring, preloaded whole by the first result
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_r[i] <= '0;
      end
    end else if (load_i) begin
      if (!primed_r) begin
        for (int i = 0; i < HIST_DEPTH; i++) begin
          hist_r[i] <= data_i;
        end
      end else begin
        hist_r[ptr_r] <= data_i;
      end
    end
  end

  // Write pointer and first-sample flag
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_r <= '0;
      primed_r <= 1'b0;
    end else if (load_i) begin
      primed_r <= 1'b1;
      if (primed_r) begin
        ptr_r <= PTR_W'(ptr_r + 3'h1);
      end
    end
  end

  // Sums kept incrementally; no divider, just shifts
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sum4_r <= '0;
      sum8_r <= '0;
    end else if (load_i) begin
      if (!primed_r) begin
        sum4_r <= {data_i, 2'b00};
        sum8_r <= {data_i, 3'b000};
      end else begin
        sum4_r <= sum4_r + {2'b00, data_i} - {2'b00, old4_w};
        sum8_r <= sum8_r + {3'b000, data_i} - {3'b000, old8_w};
      end
    end
  end

  // Truncating mean, biased low by under one LSB
  assign avg4_o = sum4_r[TEMP_W+AVG4_SHIFT-1:AVG4_SHIFT];
  assign avg8_o = sum8_r[TEMP_W+AVG8_SHIFT-1:AVG8_SHIFT];

  first_fill_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    load_i && !primed_r |=> avg8_o == $past(data_i) &&
      avg4_o == $past(data_i) && old4_w == $past(data_i))
    else $error("first result did not fill history");

  window_sum_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    load_i && primed_r |=> sum8_r == $past(sum8_r) + $past(data_i)
      - $past(old8_w) && hist_r[$past(ptr_r)] == $past(data_i))
    else $error("eight-sample window slid wrongly");

endmodule // dtf_avg

// >>> src/dtf_top.sv
`timescale 1ns/1ps
// Remote diode result filter and beta/ideality selection, APB slave
module dtf_top
  import dtf_pkg::*;
#(
  parameter bit ANTIPAR_PAIR = 1'b0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic meas_valid_i,
  input wire logic [CH_W-1:0] meas_chan_i,
  input wire logic [TEMP_W-1:0] meas_data_i,
  input wire logic conv_start_i,
  input wire logic [CH_W-1:0] conv_chan_i,
  input wire logic [3:0] beta_opt_i,
  output logic temp_valid_o,
  output logic [CH_W-1:0] temp_chan_o,
  output logic [TEMP_W-1:0] temp_data_o,
  output logic [3:0] beta_cfg_o,
  output logic [5:0] ideal_code_o,
  output logic ideal_bjt_o
);

  logic [1:0] filt_r;
  logic [3:0] auto_r;
  logic [3:0] apd_r;
  logic [3:0] beta_r [NUM_REM];
  logic [5:0] ideal_r [NUM_REM];
  logic [TEMP_W-1:0] temp_r [NUM_CH];
  logic s1_vld_r;
  logic [CH_W-1:0] s1_chan_r;
  logic [TEMP_W-1:0] s1_data_r;
  dtf_lvl_t s1_lvl_r;
  logic [TEMP_W-1:0] avg4_w [NUM_FILT];
  logic [TEMP_W-1:0] avg8_w [NUM_FILT];
  logic [TEMP_W-1:0] filt_val_c;
  logic [3:0] comp_mask_c;
  logic [3:0] auto_eff_c;
  logic elig_c;
  logic acc_c;
  logic wr_done_c;
  logic [31:0] rd_word_c;
  logic [5:0] widx_c;
  logic conv_rem_c;
  logic [1:0] conv_k_c;
  logic [3:0] beta_sel_c;

  // Mapped address: word aligned and no higher than OFS_LAST
  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_LAST);
  endfunction

  // Remote channel number to array slot
  function automatic logic [1:0] rem_idx(input logic [CH_W-1:0] ch);
    return 2'(ch - 3'h1);
  endfunction

  function automatic logic is_rem(input logic [CH_W-1:0] ch);
    return (ch != 3'h0) && (ch <= CH_LAST);
  endfunction

  // Channels 3 and 4 lose compensation on the antiparallel variant
  assign comp_mask_c = ANTIPAR_PAIR ? COMP_LOW_PAIR : COMP_ALL;
  assign auto_eff_c = auto_r & comp_mask_c;

  // APB handshake: one wait state, write lands on the completing edge
  assign acc_c = psel_i && penable_i;
  assign wr_done_c = acc_c && pready_o && pwrite_i;
  assign widx_c = paddr_i[7:2];

  // Read multiplexer; unused bits read as zero
  always_comb begin
    rd_word_c = 32'h0000_0000;
    if (paddr_i == OFS_FILT) begin
      rd_word_c[1:0] = filt_r;
    end else if (paddr_i == OFS_BCTL) begin
      rd_word_c[BCTL_AUTO_LSB+:4] = auto_eff_c;
      rd_word_c[BCTL_APD_LSB+:4] = apd_r;
    end else if (paddr_i >= OFS_BETA0 && paddr_i < OFS_IDEAL0) begin
      rd_word_c[3:0] = beta_r[2'(widx_c - OFS_BETA0[7:2])];
    end else if (paddr_i >= OFS_IDEAL0 && paddr_i < OFS_TEMP0) begin
      rd_word_c[5:0] = ideal_r[2'(widx_c - OFS_IDEAL0[7:2])];
    end else if (paddr_i >= OFS_TEMP0 && paddr_i <= OFS_LAST) begin
      rd_word_c[TEMP_W-1:0] = temp_r[3'(widx_c - OFS_TEMP0[7:2])];
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= acc_c && !pready_o;
      pslverr_o <= acc_c && !pready_o && !addr_ok(paddr_i);
      if (acc_c && !pready_o) begin
        prdata_o <= addr_ok(paddr_i) ? rd_word_c : 32'h0000_0000;
      end
    end
  end

  // Filter level and channel control words
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      filt_r <= FILT_RST;
      // Locked pair never starts with detection on
      auto_r <= ANTIPAR_PAIR ? AUTO_RST & COMP_LOW_PAIR : AUTO_RST;
      apd_r <= APD_RST;
    end else if (wr_done_c) begin
      if (paddr_i == OFS_FILT) begin
        filt_r <= pwdata_i[1:0];
      end
      if (paddr_i == OFS_BCTL) begin
        auto_r <= pwdata_i[BCTL_AUTO_LSB+:4] & comp_mask_c;
        apd_r <= pwdata_i[BCTL_APD_LSB+:4];
      end
    end
  end

  assign conv_rem_c = conv_start_i && is_rem(conv_chan_i);
  assign conv_k_c = rem_idx(conv_chan_i);

  // Beta codes: detector result wins while auto is on
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int k = 0; k < NUM_REM; k++) begin
        beta_r[k] <= BETA_DIODE;
      end
    end else begin
      for (int k = 0; k < NUM_REM; k++) begin
        if (conv_rem_c && conv_k_c == 2'(k) && auto_eff_c[k]) begin
          beta_r[k] <= beta_opt_i;
        end else if (wr_done_c && !auto_eff_c[k] && comp_mask_c[k] &&
                     paddr_i == OFS_BETA0 + 8'(4 * k)) begin
          beta_r[k] <= pwdata_i[3:0];
        end
      end
    end
  end

  // Ideality codes; a write outside the table keeps the old code
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int k = 0; k < NUM_REM; k++) begin
        ideal_r[k] <= IDEAL_RST;
      end
    end else if (wr_done_c) begin
      for (int k = 0; k < NUM_REM; k++) begin
        if (paddr_i == OFS_IDEAL0 + 8'(4 * k) &&
            pwdata_i[5:0] >= IDEAL_MIN && pwdata_i[5:0] <= IDEAL_MAX &&
            pwdata_i[31:6] == 26'h0) begin
          ideal_r[k] <= pwdata_i[5:0];
        end
      end
    end
  end

  // Setting chosen for the conversion about to run
  always_comb begin
    beta_sel_c = BETA_DIODE;
    if (!comp_mask_c[conv_k_c]) begin
      beta_sel_c = BETA_DIODE;
    end else if (auto_eff_c[conv_k_c]) begin
      beta_sel_c = beta_opt_i;
    end else begin
      beta_sel_c = beta_r[conv_k_c];
    end
  end

  // Applied settings held for the whole conversion
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      beta_cfg_o <= BETA_DIODE;
      ideal_code_o <= IDEAL_RST;
      ideal_bjt_o <= 1'b0;
    end else if (conv_start_i) begin
      if (conv_rem_c) begin
        beta_cfg_o <= beta_sel_c;
        ideal_code_o <= ideal_r[conv_k_c];
        ideal_bjt_o <= beta_sel_c != BETA_DIODE;
      end else begin
        beta_cfg_o <= BETA_DIODE;
        ideal_code_o <= IDEAL_RST;
        ideal_bjt_o <= 1'b0;
      end
    end
  end

  // Only channels 1 and 2, and only outside antiparallel mode
  assign elig_c = (meas_chan_i == 3'h1 && !apd_r[0]) ||
                  (meas_chan_i == 3'h2 && !apd_r[1]);

  // History keeps running even while filtering is off
  for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
    localparam logic [CH_W-1:0] CH = CH_W'(g + 1);
    dtf_avg u_avg (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .load_i(meas_valid_i && meas_chan_i == CH && !apd_r[g]),
      .data_i(meas_data_i),
      .avg4_o(avg4_w[g]),
      .avg8_o(avg8_w[g])
    );
  end

  // First stage: capture result and level of the moment
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_vld_r <= 1'b0;
      s1_chan_r <= '0;
      s1_data_r <= '0;
      s1_lvl_r <= DTF_LVL_NONE;
    end else begin
      s1_vld_r <= meas_valid_i && meas_chan_i <= CH_LAST;
      if (meas_valid_i) begin
        s1_chan_r <= meas_chan_i;
        s1_data_r <= meas_data_i;
        s1_lvl_r <= elig_c ? dtf_decode_lvl(filt_r) : DTF_LVL_NONE;
      end
    end
  end

  // Averages already hold the new sample here
  always_comb begin
    filt_val_c = s1_data_r;
    unique case (s1_lvl_r)
      DTF_LVL_NONE: filt_val_c = s1_data_r;
      DTF_LVL_AVG4: filt_val_c = avg4_w[s1_chan_r == 3'h2];
      DTF_LVL_AVG8: filt_val_c = avg8_w[s1_chan_r == 3'h2];
      default: filt_val_c = s1_data_r;
    endcase
  end

  // User registers and comparator feed take the same value
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      temp_valid_o <= 1'b0;
      temp_chan_o <= '0;
      temp_data_o <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        temp_r[c] <= '0;
      end
    end else begin
      temp_valid_o <= s1_vld_r;
      if (s1_vld_r) begin
        temp_chan_o <= s1_chan_r;
        temp_data_o <= filt_val_c;
        temp_r[s1_chan_r] <= filt_val_c;
      end
    end
  end

  user_reg_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    temp_valid_o |-> temp_r[temp_chan_o] == temp_data_o)
    else $error("user register differs from comparator value");

  pass_thru_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    meas_valid_i && meas_chan_i <= CH_LAST && !elig_c |=>
      ##1 temp_valid_o && temp_data_o == $past(meas_data_i, 2))
    else $error("ineligible result was altered");

  filt_off_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    meas_valid_i && meas_chan_i <= CH_LAST && filt_r == 2'b00 |=>
      ##1 temp_data_o == $past(meas_data_i, 2))
    else $error("filter off but result changed");

  no_filt_ch3_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    meas_valid_i && meas_chan_i == 3'h3 |=> s1_lvl_r == DTF_LVL_NONE
      ##1 temp_chan_o == 3'h3 && temp_data_o == $past(meas_data_i, 2))
    else $error("channel three was filtered");

  level_two_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    meas_valid_i && elig_c && filt_r == 2'b11 |=>
      s1_lvl_r == DTF_LVL_AVG8 ##1
      ((temp_chan_o == 3'h1 && temp_data_o == $past(avg8_w[0])) ||
      (temp_chan_o == 3'h2 && temp_data_o == $past(avg8_w[1]))))
    else $error("level two did not use eight-sample mean");

  beta_auto_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    conv_rem_c && auto_eff_c[conv_k_c] |=> beta_cfg_o == $past(beta_opt_i)
      && beta_r[$past(conv_k_c)] == $past(beta_opt_i))
    else $error("auto beta not applied or not shown");

  beta_man_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    conv_rem_c && !auto_eff_c[conv_k_c] && comp_mask_c[conv_k_c] |=>
      beta_cfg_o == $past(beta_r[conv_k_c]))
    else $error("manual beta code not applied");

  no_comp_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    ANTIPAR_PAIR && conv_start_i && conv_chan_i >= 3'h3 &&
      conv_chan_i <= CH_LAST |=> beta_cfg_o == BETA_DIODE && !auto_r[2]
      && !auto_r[3])
    else $error("compensation on antiparallel pair");

  ideal_apply_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    conv_rem_c |=> ideal_code_o == $past(ideal_r[conv_k_c]) &&
      ideal_code_o >= IDEAL_MIN && ideal_code_o <= IDEAL_MAX)
    else $error("wrong ideality code applied");

  apb_wait_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    psel_i && !penable_i ##1 acc_c |-> !pready_o ##1 pready_o)
    else $error("bus answer not one wait state");

  // Mean must come from the history of the channel that reported
  level_one_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    meas_valid_i && elig_c && (filt_r == 2'b01 || filt_r == 2'b10) |=>
      s1_lvl_r == DTF_LVL_AVG4 ##1
      ((temp_chan_o == 3'h1 && temp_data_o == $past(avg4_w[0])) ||
      (temp_chan_o == 3'h2 && temp_data_o == $past(avg4_w[1]))))
    else $error("level one did not use four-sample mean");

  auto_lock_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    ANTIPAR_PAIR |-> !auto_r[2] && !auto_r[3])
    else $error("auto detection enabled on antiparallel pair");

  // A refused code must leave every channel's code untouched
  ideal_keep_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    wr_done_c && paddr_i >= OFS_IDEAL0 && paddr_i < OFS_TEMP0 &&
      (pwdata_i[5:0] < IDEAL_MIN || pwdata_i[5:0] > IDEAL_MAX) |=>
      $stable(ideal_r[0]) && $stable(ideal_r[1]) && $stable(ideal_r[2])
      && $stable(ideal_r[3]))
    else $error("out-of-table ideality code was stored");

  bad_addr_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    acc_c && !pready_o && !addr_ok(paddr_i) |=> pready_o && pslverr_o &&
      prdata_o == 32'h0000_0000)
    else $error("unmapped address not refused");

  // Results of channels beyond the last one leave no trace
  chan_drop_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    meas_valid_i && meas_chan_i > CH_LAST |=> ##1 !temp_valid_o)
    else $error("result of unknown channel was stored");

endmodule // dtf_top

// >>> testbench/dtf_meas_model.sv
`timescale 1ns/1ps
// Measurement path stand-in: result strobes and conversion starts
module dtf_meas_model
  import dtf_pkg::*;
(
  input wire logic clk_i,
  output logic meas_valid_o,
  output logic [CH_W-1:0] meas_chan_o,
  output logic [TEMP_W-1:0] meas_data_o,
  output logic conv_start_o,
  output logic [CH_W-1:0] conv_chan_o,
  output logic [3:0] beta_opt_o
);
  // Idle levels at time zero
  initial begin
    meas_valid_o = 1'b0;
    meas_chan_o = 3'h0;
    meas_data_o = 11'h000;
    conv_start_o = 1'b0;
    conv_chan_o = 3'h0;
    beta_opt_o = 4'h0;
  end

  // One result; stale lines are inverted so nothing old looks valid
  task automatic send(input logic [CH_W-1:0] ch,
                      input logic [TEMP_W-1:0] d);
    meas_valid_o <= 1'b1;
    meas_chan_o <= ch;
    meas_data_o <= d;
    @(posedge clk_i);
    meas_valid_o <= 1'b0;
    meas_chan_o <= ~ch;
    meas_data_o <= ~d;
    @(posedge clk_i);
  endtask

  // Conversion start with the detector's chosen beta code
  task automatic start(input logic [CH_W-1:0] ch, input logic [3:0] opt);
    conv_start_o <= 1'b1;
    conv_chan_o <= ch;
    beta_opt_o <= opt;
    @(posedge clk_i);
    conv_start_o <= 1'b0;
    conv_chan_o <= ~ch;
    beta_opt_o <= ~opt;
    @(posedge clk_i);
  endtask
endmodule // dtf_meas_model

// >>> testbench/test_diode_temp_filter_correction.sv
`timescale 1ns/1ps
module test_diode_temp_filter_correction
  import dtf_pkg::*;
;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, mv, cs, temp_valid_o, ideal_bjt_o;
  logic [CH_W-1:0] mc, cc, temp_chan_o;
  logic [TEMP_W-1:0] md, temp_data_o;
  logic [3:0] bo, beta_cfg_o;
  logic [5:0] ideal_code_o;
  logic [31:0] rq;
  logic re;
  int failures = 0;
  int num_checks = 0;

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  // Antiparallel variant so the locked channels are reachable too
  dtf_top #(.ANTIPAR_PAIR(1'b1)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .meas_valid_i(mv),
    .meas_chan_i(mc), .meas_data_i(md), .conv_start_i(cs),
    .conv_chan_i(cc), .beta_opt_i(bo), .temp_valid_o(temp_valid_o),
    .temp_chan_o(temp_chan_o), .temp_data_o(temp_data_o),
    .beta_cfg_o(beta_cfg_o), .ideal_code_o(ideal_code_o),
    .ideal_bjt_o(ideal_bjt_o));

  dtf_meas_model meas_u (.clk_i(clk_i), .meas_valid_o(mv),
    .meas_chan_o(mc), .meas_data_o(md), .conv_start_o(cs),
    .conv_chan_o(cc), .beta_opt_o(bo));

  task automatic stop_test();
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rq = prdata_o;
    re = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rq, exp);
  endtask

  // Result in, user value checked two cycles later
  task automatic meas(input logic [2:0] ch, input logic [10:0] d,
                      input logic ev, input logic [10:0] exp);
    meas_u.send(ch, d);
    #1;
    chk("tvalid", {31'h0, temp_valid_o}, {31'h0, ev});
    if (ev) begin
      chk("tchan", {29'h0, temp_chan_o}, {29'h0, ch});
      chk("tdata", {21'h0, temp_data_o}, {21'h0, exp});
    end
    @(posedge clk_i);
  endtask

  task automatic conv(input logic [2:0] ch, input logic [3:0] opt,
                      input logic [3:0] eb, input logic [5:0] ei);
    meas_u.start(ch, opt);
    chk("beta", {28'h0, beta_cfg_o}, {28'h0, eb});
    chk("ideal", {26'h0, ideal_code_o}, {26'h0, ei});
    chk("bjt", {31'h0, ideal_bjt_o}, {31'h0, eb != 4'hF});
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    stop_test();
  end

  logic [5:0] icode [4] = '{6'h08, 6'h37, 6'h07, 6'h38};
  logic [5:0] iexp [4] = '{6'h08, 6'h37, 6'h12, 6'h12};

  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rdc("filt", OFS_FILT, 32'h0);
    rdc("bctl", OFS_BCTL, 32'h3);
    wr(OFS_BCTL, 32'hF);
    rdc("bctllk", OFS_BCTL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      rdc("idrst", OFS_IDEAL0 + 8'(4 * i), 32'h12);
      rdc("btrst", OFS_BETA0 + 8'(4 * i), 32'hF);
    end
    xfer(1'b0, 8'h3C, 32'h0);
    chk("unmap", {31'h0, re}, 32'h1);
    chk("unmapd", rq, 32'h0);
    // Per-channel ideality, both legal ends and both illegal neighbours
    for (int i = 0; i < 4; i++) begin
      wr(OFS_IDEAL0 + 8'(4 * i), {26'h0, icode[i]});
      rdc("idl", OFS_IDEAL0 + 8'(4 * i), {26'h0, iexp[i]});
    end
    // First result fills the history; filter off passes it through
    meas(3'h1, 11'd100, 1'b1, 11'd100);
    wr(OFS_TEMP0 + 8'h4, 32'h5);
    rdc("t1", OFS_TEMP0 + 8'h4, 32'd100);
    wr(OFS_FILT, 32'h1);
    meas(3'h1, 11'd200, 1'b1, 11'd125);
    wr(OFS_FILT, 32'h2);
    meas(3'h1, 11'd200, 1'b1, 11'd150);
    wr(OFS_FILT, 32'h3);
    meas(3'h1, 11'd200, 1'b1, 11'd137);
    meas(3'h1, 11'h7FF, 1'b1, 11'd380);
    rdc("t1f", OFS_TEMP0 + 8'h4, 32'd380);
    meas(3'h3, 11'd500, 1'b1, 11'd500);
    meas(3'h0, 11'd7, 1'b1, 11'd7);
    meas(3'h5, 11'd9, 1'b0, 11'd0);
    meas(3'h2, 11'd40, 1'b1, 11'd40);
    meas(3'h2, 11'd80, 1'b1, 11'd45);
    wr(OFS_BCTL, 32'h23);
    meas(3'h2, 11'd800, 1'b1, 11'd800);
    // Auto beta shown and applied; software write blocked meanwhile
    conv(3'h1, 4'h5, 4'h5, 6'h08);
    rdc("bt1", OFS_BETA0, 32'h5);
    wr(OFS_BETA0, 32'h2);
    rdc("bt1w", OFS_BETA0, 32'h5);
    conv(3'h3, 4'h5, 4'hF, 6'h12);
    wr(OFS_BETA0 + 8'h8, 32'h2);
    rdc("bt3", OFS_BETA0 + 8'h8, 32'hF);
    conv(3'h0, 4'h5, 4'hF, 6'h12);
    wr(OFS_BCTL, 32'h0);
    wr(OFS_BETA0, 32'h3);
    conv(3'h1, 4'h9, 4'h3, 6'h08);
    wr(OFS_BETA0, 32'hF);
    conv(3'h1, 4'h9, 4'hF, 6'h08);
    conv(3'h2, 4'h9, 4'hF, 6'h37);
    stop_test();
  end
endmodule // test_diode_temp_filter_correction
